// File: rtl/fbcsm_top.sv
`include "fbcsm_params.svh"
module fbcsm_top #(
  parameter int NUM_BANKS = `FBCSM_NUM_BANKS,
  parameter int BANK_W    = $clog2(`FBCSM_NUM_BANKS)
) (
  // Clock, reset, enable
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_ce,
  // Command write cycle
  input  wire logic                         i_wr,
  input  wire logic [BANK_W-1:0]            i_bank,
  input  wire logic [7:0]                   i_cmd,
  // Program/erase controller
  input  wire logic                         i_pec_active,
  input  wire logic                         i_pec_suspended,
  input  wire logic                         i_pec_done,
  // Error events to the status word
  input  wire logic                         i_err_set,
  // Read side
  input  wire logic [BANK_W-1:0]            i_rd_bank,
  output fbcsm_pkg::fbcsm_out_t             o_rd_mode,
  output logic                              o_rd_undef,
  // Interface state and status
  output fbcsm_pkg::fbcsm_state_t           o_state,
  output logic                              o_lock_err,
  output logic                              o_err
);
  import fbcsm_pkg::*;

  fbcsm_state_t             state;            // Interface state
  fbcsm_out_t               mode [NUM_BANKS]; // Per-bank output mode
  logic [NUM_BANKS-1:0]     busy_bank;        // Banks with operation underway
  logic                     lock_err;         // Sticky lock error
  logic                     err;              // Sticky general error
  fbcsm_state_t             next_state;       // Next interface state
  logic                     next_lock_err;    // Lock error raise
  logic                     setup_cmd;        // Write is a two-cycle first cycle

  // Classify first cycles of two-cycle commands
  function automatic logic is_setup(input logic [7:0] c);
    is_setup = (c == `FBCSM_CMD_LOCK_SETUP) || (c == `FBCSM_CMD_OTP_SETUP) ||
               (c == `FBCSM_CMD_PROG_SETUP);
  endfunction

  assign setup_cmd = is_setup(i_cmd);

  // Next state from state, write command and controller active/done flags only
  always_comb begin
    next_state    = state;
    next_lock_err = 1'b0;
    case (state)
      FBCSM_READY: begin
        if (i_wr && !i_pec_active) begin // Setup ignored while active
          if (i_cmd == `FBCSM_CMD_LOCK_SETUP) next_state = FBCSM_LOCK_SETUP;
          else if (i_cmd == `FBCSM_CMD_OTP_SETUP) next_state = FBCSM_OTP_SETUP;
          else if (i_cmd == `FBCSM_CMD_PROG_SETUP) next_state = FBCSM_PROG_SETUP;
        end
      end
      FBCSM_LOCK_SETUP: begin
        if (i_wr) begin
          next_state = FBCSM_READY;
          next_lock_err = !(i_cmd == `FBCSM_CMD_LOCK_CONF || i_cmd == `FBCSM_CMD_LOCKDN_CONF ||
                            i_cmd == `FBCSM_CMD_SETCFG_CONF);
        end
      end
      FBCSM_OTP_SETUP:  if (i_wr) next_state = FBCSM_OTP_BUSY;
      FBCSM_PROG_SETUP: if (i_wr) next_state = FBCSM_PROG_BUSY;
      FBCSM_OTP_BUSY, FBCSM_PROG_BUSY: begin
        if (i_pec_done) next_state = FBCSM_READY;
      end
      default: next_state = FBCSM_READY;
    endcase
  end

  // Interface state register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) state <= FBCSM_READY;
    else if (i_ce) state <= next_state;
  end

  // Per-bank output mode, held until a new command
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      for (int b = 0; b < NUM_BANKS; b++) mode[b] <= FBCSM_OUT_ARRAY;
    end else if (i_ce && i_wr) begin
      if (state == FBCSM_READY && !(i_pec_active && setup_cmd)) begin
        case (i_cmd)
          `FBCSM_CMD_READ_ARRAY:  mode[i_bank] <= FBCSM_OUT_ARRAY;
          `FBCSM_CMD_READ_STATUS: mode[i_bank] <= FBCSM_OUT_STATUS;
          `FBCSM_CMD_READ_SIG:    mode[i_bank] <= FBCSM_OUT_SIG;
          `FBCSM_CMD_READ_QUERY:  mode[i_bank] <= FBCSM_OUT_QUERY;
          `FBCSM_CMD_OTP_SETUP,
          `FBCSM_CMD_PROG_SETUP:  mode[i_bank] <= FBCSM_OUT_STATUS;
          default: ;
        endcase
      end else if (state == FBCSM_OTP_BUSY || state == FBCSM_PROG_BUSY) begin
        // Busy: only read commands move the output, setups stay ignored
        case (i_cmd)
          `FBCSM_CMD_READ_ARRAY:  mode[i_bank] <= FBCSM_OUT_ARRAY; // Data undefined on busy bank
          `FBCSM_CMD_READ_STATUS: mode[i_bank] <= FBCSM_OUT_STATUS;
          `FBCSM_CMD_READ_SIG:    mode[i_bank] <= (state == FBCSM_OTP_BUSY) ? FBCSM_OUT_STATUS : FBCSM_OUT_SIG;
          `FBCSM_CMD_READ_QUERY:  mode[i_bank] <= (state == FBCSM_OTP_BUSY) ? FBCSM_OUT_STATUS : FBCSM_OUT_QUERY;
          default: ;              // Other codes leave the output unchanged
        endcase
      end else if (state != FBCSM_READY) begin
        mode[i_bank] <= FBCSM_OUT_STATUS; // Second cycle shows status
      end
    end
  end

  // Track which bank runs a program
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) busy_bank <= '0;
    else if (i_ce) begin
      if (i_pec_done) busy_bank <= '0;
      else if (i_wr && (state == FBCSM_OTP_SETUP || state == FBCSM_PROG_SETUP))
        busy_bank[i_bank] <= 1'b1;
    end
  end

  // Error flags: set wins over clear; clear blocked when busy/suspended
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      lock_err <= 1'b0;
      err      <= 1'b0;
    end else if (i_ce) begin
      if (next_lock_err) lock_err <= 1'b1;
      else if (i_wr && state == FBCSM_READY && i_cmd == `FBCSM_CMD_CLR_STATUS &&
               !i_pec_active && !i_pec_suspended) lock_err <= 1'b0;
      if (i_err_set) err <= 1'b1;
      else if (i_wr && state == FBCSM_READY && i_cmd == `FBCSM_CMD_CLR_STATUS &&
               !i_pec_active && !i_pec_suspended) err <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rd_mode  <= FBCSM_OUT_ARRAY;
      o_rd_undef <= 1'b0;
      o_state    <= FBCSM_READY;
      o_lock_err <= 1'b0;
      o_err      <= 1'b0;
    end else if (i_ce) begin
      o_rd_mode  <= mode[i_rd_bank];
      o_rd_undef <= busy_bank[i_rd_bank] && mode[i_rd_bank] == FBCSM_OUT_ARRAY;
      o_state    <= state;
      o_lock_err <= lock_err;
      o_err      <= err;
    end
  end

  // Reset leaves ready with array mode
  property p_reset_ready;
    @(posedge i_clk) !i_reset_n |=> state == FBCSM_READY && mode[0] == FBCSM_OUT_ARRAY;
  endproperty
  a_reset_ready: assert property (p_reset_ready) else $error("reset state wrong");

  // Setup ignored while controller active
  property p_ignore_active;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_wr && i_pec_active && state == FBCSM_READY |=> state == FBCSM_READY;
  endproperty
  a_ignore_active: assert property (p_ignore_active) else $error("setup taken while active");

  // Lock confirm returns ready without error
  property p_lock_ok;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_wr && state == FBCSM_LOCK_SETUP && i_cmd == `FBCSM_CMD_LOCK_CONF
      |=> state == FBCSM_READY ##1 o_lock_err == $past(o_lock_err, 1);
  endproperty
  a_lock_ok: assert property (p_lock_ok) else $error("lock confirm wrong");

  // Bad lock second cycle flags error
  property p_lock_bad;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_wr && state == FBCSM_LOCK_SETUP && next_lock_err |=> lock_err && state == FBCSM_READY;
  endproperty
  a_lock_bad: assert property (p_lock_bad) else $error("lock error missing");

  // Setup then busy then ready
  sequence s_prog_start;
    i_ce && i_wr && state == FBCSM_PROG_SETUP;
  endsequence
  property p_prog_busy;
    @(posedge i_clk) disable iff (!i_reset_n) s_prog_start |=> state == FBCSM_PROG_BUSY;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("program busy not entered");

  property p_busy_done;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_pec_done && (state == FBCSM_PROG_BUSY || state == FBCSM_OTP_BUSY) |=> state == FBCSM_READY;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("busy did not end");

  // Clear kept while suspended
  property p_clr_blocked;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && (i_pec_active || i_pec_suspended) && err |=> err;
  endproperty
  a_clr_blocked: assert property (p_clr_blocked) else $error("error cleared while busy");

  // Read status sets bank mode; holds without writes
  property p_mode_sel;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_wr && state == FBCSM_READY && i_cmd == `FBCSM_CMD_READ_STATUS
      |=> mode[$past(i_bank, 1)] == FBCSM_OUT_STATUS;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode not selected");

  property p_mode_hold;
    @(posedge i_clk) disable iff (!i_reset_n) !i_wr |=> mode[0] == $past(mode[0], 1);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

  // Read array in a busy state still switches that bank to array output
  property p_busy_array;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_wr && (state == FBCSM_OTP_BUSY || state == FBCSM_PROG_BUSY) &&
      i_cmd == `FBCSM_CMD_READ_ARRAY |=> mode[$past(i_bank, 1)] == FBCSM_OUT_ARRAY;
  endproperty
  a_busy_array: assert property (p_busy_array) else $error("busy bank array mode not taken");

  // Writes during a busy state never move the interface
  property p_busy_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_ce && i_wr && !i_pec_done && (state == FBCSM_OTP_BUSY || state == FBCSM_PROG_BUSY)
      |=> state == $past(state, 1);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy state left on a write");
endmodule // fbcsm_top

// File: rtl/fbcsm_params.svh
`ifndef FBCSM_PARAMS_SVH
`define FBCSM_PARAMS_SVH
// Summary of operation
// - Power-up puts every bank in array read
// - Array read of busy bank gives undefined data
// - Setup commands ignored while controller active
// - Clear status clears errors unless busy/suspended
// - Output mode applies to command's addressed bank
// - Four modes: array, status, signature, query
// - Bank holds output mode until new command
// - Next state ignores the bank output mode

// Command codes on the low data byte
`define FBCSM_CMD_READ_ARRAY  8'hFF
`define FBCSM_CMD_READ_STATUS 8'h70
`define FBCSM_CMD_READ_SIG    8'h90
`define FBCSM_CMD_READ_QUERY  8'h98
`define FBCSM_CMD_CLR_STATUS  8'h50
`define FBCSM_CMD_LOCK_SETUP  8'h60
`define FBCSM_CMD_OTP_SETUP   8'hC0
`define FBCSM_CMD_PROG_SETUP  8'h40
`define FBCSM_CMD_LOCK_CONF   8'h01
`define FBCSM_CMD_LOCKDN_CONF 8'h2F
`define FBCSM_CMD_SETCFG_CONF 8'h03
// Default bank count
`define FBCSM_NUM_BANKS       8
`endif

// File: rtl/fbcsm_pkg.sv
package fbcsm_pkg;
  // Command interface states
  typedef enum logic [2:0] {
    FBCSM_READY, FBCSM_LOCK_SETUP, FBCSM_OTP_SETUP, FBCSM_OTP_BUSY,
    FBCSM_PROG_SETUP, FBCSM_PROG_BUSY
  } fbcsm_state_t;
  // Per-bank output modes
  typedef enum logic [1:0] {
    FBCSM_OUT_ARRAY, FBCSM_OUT_STATUS, FBCSM_OUT_SIG, FBCSM_OUT_QUERY
  } fbcsm_out_t;
endpackage

// File: bench/fbcsm_host.sv
module fbcsm_host (
  // Clock
  input  wire logic       i_clk,
  // Command write cycle towards the device
  output logic            o_wr,
  output logic [2:0]      o_bank,
  output logic [7:0]      o_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    o_wr = 1'b0;
    o_bank = 3'h0;
    o_cmd = 8'h00;
  end
  // One write pulse; caller keeps both cycles on one bank
  task automatic send(input logic [2:0] b, input logic [7:0] c);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_bank = b;
    o_cmd = c;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_bank = ~b;  // Released lines show the inverse
    o_cmd = ~c;
  endtask
endmodule // fbcsm_host

// File: bench/flash_bank_command_state_machine_tb.sv
module flash_bank_command_state_machine_tb;
  import fbcsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus and observed signals
  logic i_clk = 1'b0, i_reset_n = 1'b0, act = 1'b0, susp = 1'b0, done = 1'b0, eset = 1'b0, ce = 1'b1;
  logic wr, undef, lock_err, err;
  logic [2:0] bank, rd_bank = 3'h0;
  logic [7:0] cmd;
  fbcsm_out_t rd_mode;
  fbcsm_state_t state;
  // Reference model and bookkeeping
  int st = 0, le = 0, er = 0, fails = 0, samples_checked = 0, cyc = 0, rb = 0;
  logic [7:0] bz = 8'h00;  // Banks with a program underway
  int md[8] = '{default: 0};
  logic [31:0] rng = 32'h0000_04B9;
  int codes[11] = '{'hFF, 'h70, 'h90, 'h98, 'h50, 'h60, 'hC0, 'h40, 'h01, 'h2F, 'h03};
  int conf[4] = '{'h01, 'h2F, 'h03, 'h55};
  // Clock of 100 ns
  always #50 i_clk = ~i_clk;
  fbcsm_host i_fbcsm_host (.i_clk(i_clk), .o_wr(wr), .o_bank(bank), .o_cmd(cmd));
  fbcsm_top i_fbcsm_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(ce), .i_wr(wr), .i_bank(bank),
    .i_cmd(cmd), .i_pec_active(act), .i_pec_suspended(susp), .i_pec_done(done), .i_err_set(eset),
    .i_rd_bank(rd_bank), .o_rd_mode(rd_mode), .o_rd_undef(undef), .o_state(state),
    .o_lock_err(lock_err), .o_err(err));
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // Compare state, flags and every bank's mode
  task automatic cmp();
    chk("state", state, st[7:0]);
    chk("lock_err", lock_err, le[7:0]);
    chk("err", err, er[7:0]);
    for (int i = 0; i < 8; i++) begin
      rd_bank = i[2:0];
      @(negedge i_clk);
      chk("mode", rd_mode, md[i][7:0]);
      chk("undef", undef, {7'h00, bz[i] && md[i] == 0});
    end
  endtask
  // Model one write, send it, then compare
  task automatic go(input int b, input int c);
    if (st == 0) begin
      if (c == 'hFF) md[b] = 0;
      if (c == 'h70) md[b] = 1;
      if (c == 'h90) md[b] = 2;
      if (c == 'h98) md[b] = 3;
      if (c == 'h50 && !act && !susp) begin
        le = 0;
        er = 0;
      end
      if (!act && c inside {'h60, 'hC0, 'h40}) begin
        if (c != 'h60) md[b] = 1;  // Lock setup leaves the output alone
        st = (c == 'h60) ? 1 : (c == 'hC0) ? 2 : 4;
      end
    end else if (st == 1) begin
      le |= !(c inside {'h01, 'h2F, 'h03});
      st = 0;
      md[b] = 1;
    end else if (st == 2 || st == 4) begin
      st++;
      md[b] = 1;
      bz[b] = 1'b1;
    end else begin
      // Busy: reads still pick the output, other writes are dropped
      if (c == 'hFF) md[b] = 0;
      if (c == 'h70) md[b] = 1;
      if (c == 'h90) md[b] = (st == 3) ? 1 : 2;
      if (c == 'h98) md[b] = (st == 3) ? 1 : 3;
    end
    i_fbcsm_host.send(b[2:0], c[7:0]);
    repeat (2) @(negedge i_clk);
    cmp();
  endtask
  // Completion pulse from the controller
  task automatic end_pec();
    @(negedge i_clk);
    done = 1'b1;
    act = 1'b0;
    @(negedge i_clk);
    done = 1'b0;
    if (st == 3 || st == 5) st = 0;
    bz = 8'h00;
    repeat (2) @(negedge i_clk);
    cmp();
  endtask
  task automatic pulse_err();
    @(negedge i_clk);
    eset = 1'b1;
    @(negedge i_clk);
    eset = 1'b0;
    er = 1;
  endtask
  task automatic wrap_up();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    cmp();
    for (int k = 0; k < 4; k++) go(xs() % 8, codes[k]);
    foreach (conf[k]) begin
      go(k, 'h60);
      go(k, conf[k]);
    end
    act = 1'b1;
    for (int k = 5; k < 8; k++) go(2, codes[k]);
    go(2, 'h50);
    act = 1'b0;
    pulse_err();
    susp = 1'b1;
    go(1, 'h50);
    susp = 1'b0;
    go(1, 'h50);
    go(3, 'hC0);
    go(3, 'h5A);
    act = 1'b1;
    go(3, 'hFF);
    go(3, 'h98);
    end_pec();
    go(6, 'h40);
    go(6, 'h33);
    act = 1'b1;
    go(6, 'h60);
    go(6, 'h90);
    go(6, 'hFF);
    end_pec();
    for (int n = 0; n < 40; n++) begin
      if (!(st inside {1, 2, 4})) rb = xs() % 8;  // Second cycle stays on the first bank
      go(rb, codes[xs() % 11]);
      if (st == 3 || st == 5) end_pec();
    end
    go(rb, 'h98);
    // Reset in mid-run returns every bank to array output
    @(negedge i_clk);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_reset_n = 1'b1;
    st = 0;
    le = 0;
    er = 0;
    bz = 8'h00;
    md = '{default: 0};
    cmp();
    // A write with the clock enable low must be lost
    ce = 1'b0;
    i_fbcsm_host.send(3'h0, 8'h70);
    ce = 1'b1;
    repeat (2) @(negedge i_clk);
    cmp();
    wrap_up();
  end
endmodule // flash_bank_command_state_machine_tb
